// [hdl/fcpc_ctrl.sv]
module fcpc_ctrl #(
	parameter int MAX_LOW_CYCLES = fcpc_pkg::MAX_LOW_CYC,
	parameter int PRECHARGE_CYCLES = fcpc_pkg::PRECHARGE_CYC
)(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_supply_ok,
	input wire logic i_req_valid,
	input wire logic i_req_write,
	input wire logic [fcpc_pkg::ADDR_W-1:0] i_req_addr,
	input wire logic [fcpc_pkg::DATA_W-1:0] i_req_wdata,
	output logic o_req_ready,
	output logic o_rd_valid,
	output logic [fcpc_pkg::DATA_W-1:0] o_rd_data,
	output logic [fcpc_pkg::ROW_W-1:0] o_row_addr,
	output logic o_row_wear,
	output logic o_chip_sel_n,
	output logic o_write_n,
	output logic o_out_en_n,
	output logic [fcpc_pkg::ADDR_W-1:0] o_addr,
	input wire logic [fcpc_pkg::DATA_W-1:0] i_dq,
	output logic [fcpc_pkg::DATA_W-1:0] o_dq,
	output logic o_dq_oe
);
	import fcpc_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic sup_meta_reg;
	logic sup_sync_reg;
	logic [DATA_W-1:0] dq_meta_reg;
	logic [DATA_W-1:0] dq_sync_reg;
	fcpc_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic write_reg;

	localparam logic [CNT_W-1:0] ACC_LAST = CNT_W'(ACCESS_CYC + 2);
	localparam logic [CNT_W-1:0] PC_LAST = CNT_W'(PRECHARGE_CYCLES - 1);
	localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(MAX_LOW_CYCLES - 1);

	// Two flops on supply flag and data pins
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sup_meta_reg <= 1'b0;
			sup_sync_reg <= 1'b0;
			dq_meta_reg <= '0;
			dq_sync_reg <= '0;
		end
		else
		begin
			sup_meta_reg <= i_supply_ok;
			sup_sync_reg <= sup_meta_reg;
			dq_meta_reg <= i_dq;
			dq_sync_reg <= dq_meta_reg;
		end
	end

	// ----------------------------------------
	// Cycle sequencer
	// ----------------------------------------
	logic low_done;
	assign low_done = (cnt_reg == ACC_LAST) || (cnt_reg == LOW_LAST);

	// State, counter and latched request
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_reg <= ST_POWER;
			cnt_reg <= '0;
			write_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_POWER:
				begin
					cnt_reg <= '0;
					if (sup_sync_reg)
						state_reg <= ST_IDLE;
				end
				ST_IDLE:
				begin
					cnt_reg <= '0;
					if (!sup_sync_reg)
						state_reg <= ST_POWER;
					else if (i_req_valid)
					begin
						state_reg <= ST_ACCESS;
						write_reg <= i_req_write;
					end
				end
				ST_ACCESS:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					if (low_done)
					begin
						state_reg <= ST_PRECHG;
						cnt_reg <= '0;
					end
				end
				ST_PRECHG:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg >= PC_LAST)
					begin
						state_reg <= sup_sync_reg ? ST_IDLE : ST_POWER;
						cnt_reg <= '0;
					end
				end
				default:
				begin
					state_reg <= ST_POWER;
					cnt_reg <= '0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// Select, strobes, address and data
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_chip_sel_n <= 1'b1;
			o_write_n <= 1'b1;
			o_out_en_n <= 1'b1;
			o_addr <= '0;
			o_dq <= '0;
			o_dq_oe <= 1'b0;
		end
		else
		begin
			if (state_reg == ST_IDLE && sup_sync_reg && i_req_valid)
			begin
				o_addr <= i_req_addr;
				o_dq <= i_req_wdata;
				o_write_n <= !i_req_write;
				o_dq_oe <= i_req_write;
				o_out_en_n <= i_req_write;
				o_chip_sel_n <= 1'b0;
			end
			else if (state_reg == ST_ACCESS && low_done)
			begin
				o_chip_sel_n <= 1'b1;
				o_write_n <= 1'b1;
				o_out_en_n <= 1'b1;
				o_dq_oe <= 1'b0;
			end
			else if (state_reg == ST_POWER)
			begin
				o_chip_sel_n <= 1'b1;
				o_write_n <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// User answers
	// ----------------------------------------
	// Ready, read data and row wear report
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_req_ready <= 1'b0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
			o_row_addr <= '0;
			o_row_wear <= 1'b0;
		end
		else
		begin
			o_req_ready <= (state_reg == ST_PRECHG) && (cnt_reg >= PC_LAST) && sup_sync_reg;
			o_rd_valid <= 1'b0;
			o_row_wear <= 1'b0;
			if (state_reg == ST_ACCESS && low_done)
			begin
				o_rd_valid <= !write_reg;
				o_rd_data <= dq_sync_reg;
				o_row_addr <= o_addr[ADDR_W-1:ROW_LSB];
				o_row_wear <= 1'b1;
			end
			else if (state_reg == ST_IDLE && (!sup_sync_reg || i_req_valid))
				o_req_ready <= 1'b0;
			else if (state_reg == ST_IDLE)
				o_req_ready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [CNT_W-1:0] high_cnt_reg;
	// Length of current select-high stretch
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			high_cnt_reg <= '0;
		else if (o_chip_sel_n && high_cnt_reg != '1)
			high_cnt_reg <= high_cnt_reg + 1'b1;
		else if (!o_chip_sel_n)
			high_cnt_reg <= '0;
	end

	sequence s_fall;
		$fell(o_chip_sel_n);
	endsequence

	property p_precharge;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_fall |-> $past(high_cnt_reg) >= PC_LAST + 1'b1;
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge too short");

	property p_low_max;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		!o_chip_sel_n |-> cnt_reg <= LOW_LAST;
	endproperty
	a_low_max: assert property (p_low_max) else $error("select low too long");

	property p_low_len;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_fall |-> !o_chip_sel_n [*8];
	endproperty
	a_low_len: assert property (p_low_len) else $error("access phase cut short");

	property p_power;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state_reg == ST_POWER) |=> o_chip_sel_n && o_write_n;
	endproperty
	a_power: assert property (p_power) else $error("pins low during ramp");

	property p_addr_stable;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		!o_chip_sel_n && $past(!o_chip_sel_n) |-> $stable(o_addr);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved");

	property p_write_start;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		s_fall |-> (o_write_n != o_dq_oe) && (o_out_en_n != o_write_n);
	endproperty
	a_write_start: assert property (p_write_start) else $error("strobe mismatch");

	property p_wear;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(o_chip_sel_n) |-> o_row_wear && o_row_addr == o_addr[ADDR_W-1:ROW_LSB];
	endproperty
	a_wear: assert property (p_wear) else $error("row wear missing");

	property p_own_fall;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(o_chip_sel_n) |=> o_chip_sel_n [*8];
	endproperty
	a_own_fall: assert property (p_own_fall) else $error("no fresh select fall");
endmodule : fcpc_ctrl

// [hdl/fcpc_pkg.sv]
package fcpc_pkg;
	// ----------------------------------------
	// Widths and timing
	// ----------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int ROW_LSB = 3; // Row select starts above byte-in-row bits
	localparam int ROW_W = ADDR_W - ROW_LSB;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int MIN_PRECHARGE_INTERVAL_PS = 60000;
	localparam int MAX_LOW_TIME_PS = 10000000;
	localparam int ACCESS_TIME_PS = 70000;
	// Least times round up
	localparam int PRECHARGE_CYC =
		(MIN_PRECHARGE_INTERVAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACCESS_CYC = (ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Longest time rounds down
	localparam int MAX_LOW_CYC = MAX_LOW_TIME_PS / CLK_PERIOD_PS;
	// Counter spans the longest select-low stretch
	localparam int CNT_W = $clog2(MAX_LOW_CYC + 1);

	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_POWER = 4'h1,
		ST_IDLE = 4'h2,
		ST_ACCESS = 4'h4,
		ST_PRECHG = 4'h8
	} fcpc_state_t;
endpackage : fcpc_pkg

// [tb/fcpc_fram_model.sv]
module fcpc_fram_model (
	input wire logic i_chip_sel_n,
	input wire logic i_write_n,
	input wire logic i_out_en_n,
	input wire logic [fcpc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fcpc_pkg::DATA_W-1:0] i_dq,
	input wire logic i_dq_oe,
	output logic [fcpc_pkg::DATA_W-1:0] o_dq,
	output logic [fcpc_pkg::ROW_W-1:0] o_row
);
	timeunit 1ns;
	timeprecision 1ps;
	import fcpc_pkg::*;
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0] lat = '0;
	logic wr_cyc = 1'b0;
	logic data_ok = 1'b0;
	// Known fill so stale bus values are never unknown
	initial
	begin
		foreach (mem[i]) mem[i] = 8'h5A;
	end
	// Latch address and mode at select fall, no supply lockout
	always @(negedge i_chip_sel_n)
	begin
		// Let pins updated in the same step settle
		#0.1;
		lat = i_addr;
		wr_cyc = !i_write_n;
		o_row = i_addr[ADDR_W-1:ROW_LSB];
		data_ok = 1'b0;
		#70 data_ok = 1'b1;
	end
	// Precharge starts only at select rise
	always @(posedge i_chip_sel_n)
	begin
		data_ok = 1'b0;
		wr_cyc = 1'b0;
	end
	// Store bus data while the write strobe is low
	always @*
	begin
		if (!i_chip_sel_n && wr_cyc && !i_write_n && i_dq_oe)
			mem[lat] = i_dq;
	end
	// Drive reads only; released bus shows the inverse
	assign o_dq = (!i_chip_sel_n && !wr_cyc && !i_out_en_n && data_ok) ? mem[lat] : ~mem[lat];
endmodule : fcpc_fram_model

// [tb/fram_cycle_precharge_control_test.sv]
module fram_cycle_precharge_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fcpc_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic supply_ok = 1'b0;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic req_ready, rd_valid, row_wear, chip_sel_n, write_n, out_en_n, dq_oe;
	logic [DATA_W-1:0] rd_data, dq_in, dq_out;
	logic [ROW_W-1:0] row_addr, dev_row;
	logic [ADDR_W-1:0] pin_addr;
	int miscompares = 0;
	int total_checks = 0;
	int low_cnt = 0;
	int high_cnt = 100;
	int falls = 0;
	int done = 0;
	always #2 ref_clk = ~ref_clk;
	fcpc_ctrl #(.MAX_LOW_CYCLES(32), .PRECHARGE_CYCLES(15)) u_dut (.i_ref_clk(ref_clk),
		.i_rst_n(rst_n), .i_supply_ok(supply_ok), .i_req_valid(req_valid),
		.i_req_write(req_write), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
		.o_req_ready(req_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
		.o_row_addr(row_addr), .o_row_wear(row_wear), .o_chip_sel_n(chip_sel_n),
		.o_write_n(write_n), .o_out_en_n(out_en_n), .o_addr(pin_addr), .i_dq(dq_in),
		.o_dq(dq_out), .o_dq_oe(dq_oe));
	fcpc_fram_model u_fram (.i_chip_sel_n(chip_sel_n), .i_write_n(write_n),
		.i_out_en_n(out_en_n), .i_addr(pin_addr), .i_dq(dq_out), .i_dq_oe(dq_oe),
		.o_dq(dq_in), .o_row(dev_row));
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	task automatic bail(input int n, input int lim);
		if (n >= lim)
		begin
			miscompares++;
			end_sim();
		end
	endtask : bail
	// Select run lengths: access window and precharge gap
	always @(negedge ref_clk)
	begin
		if (chip_sel_n === 1'b0)
		begin
			if (high_cnt > 0)
			begin
				falls++;
				check("precharge", 1, high_cnt >= 15);
			end
			high_cnt = 0;
			low_cnt++;
		end
		else
		begin
			if (low_cnt > 0)
				check("low time", 1, low_cnt >= ACCESS_CYC && low_cnt <= 32);
			low_cnt = 0;
			high_cnt++;
		end
	end
	// Supply low with a request pending: no access at all
	task automatic t_power();
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		req_valid <= 1'b1;
		repeat (20)
		begin
			@(negedge ref_clk);
			check("sel_n", 1, chip_sel_n);
			check("we_n", 1, write_n);
			check("ready", 0, req_ready);
		end
		@(posedge ref_clk);
		req_valid <= 1'b0;
		supply_ok <= 1'b1;
	endtask : t_power
	// One transfer; address moves right after the take
	task automatic t_xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (req_ready !== 1'b1 && n < 100);
		bail(n, 100);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(negedge ref_clk);
		check("ready", 1, req_ready);
		@(posedge ref_clk);
		req_valid <= 1'b0;
		req_addr <= ~a;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (row_wear !== 1'b1 && n < 60);
		bail(n, 60);
		check("row", a[ADDR_W-1:ROW_LSB], row_addr);
		check("dev row", a[ADDR_W-1:ROW_LSB], dev_row);
		check("rd valid", !w, rd_valid);
		if (!w)
			check("rd data", d, rd_data);
		done++;
	endtask : t_xfer
	// Supply droop mid-run with a request raised: no access
	task automatic t_droop();
		@(posedge ref_clk);
		supply_ok <= 1'b0;
		repeat (4) @(negedge ref_clk);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_write <= 1'b1;
		repeat (20)
		begin
			@(negedge ref_clk);
			check("droop sel_n", 1, chip_sel_n);
			check("droop we_n", 1, write_n);
			check("droop ready", 0, req_ready);
		end
		@(posedge ref_clk);
		req_valid <= 1'b0;
		supply_ok <= 1'b1;
	endtask : t_droop
	initial
	begin
		t_power();
		t_xfer(1'b1, 15'h0007, 8'hA5);
		t_xfer(1'b1, 15'h0008, 8'h3C);
		t_xfer(1'b1, 15'h7FFF, 8'hC3);
		t_droop();
		t_xfer(1'b0, 15'h0007, 8'hA5);
		t_xfer(1'b0, 15'h0008, 8'h3C);
		t_xfer(1'b0, 15'h7FFF, 8'hC3);
		repeat (20) @(negedge ref_clk);
		check("falls", done, falls);
		end_sim();
	end
endmodule : fram_cycle_precharge_control_test
